// >>> design/cltd_pkg.sv
// Purpose: constants for the channel level trigger detector
// Assumes: 12 bit samples, 8 bit signed thresholds, plain register port
// Notes:   register offsets are word addresses as printed
package cltd_pkg;
  // ==========================================================
  // register map
  localparam logic [15:0] ADDR_SOURCE_SELECT = 16'h9C40;
  localparam logic [15:0] ADDR_CH0_KIND      = 16'h9D08;
  localparam logic [15:0] ADDR_CH0_UPPER     = 16'hA410;
  localparam logic [15:0] ADDR_CH0_LOWER     = 16'hA474;
  localparam logic [15:0] ADDR_PULSE_SPAN    = 16'hABE0;
  localparam logic [15:0] ADDR_IRQ_STATUS    = 16'hAC00;
  localparam logic [15:0] ADDR_IRQ_MASK      = 16'hAC04;
  localparam logic [15:0] ADDR_DET_STATUS    = 16'hAC08;
  // ==========================================================
  // codes
  localparam logic [31:0] SRC_PER_CHANNEL    = 32'h0000_4E48; // 20040
  localparam logic [31:0] KIND_RISE          = 32'h0000_2710; // 10000
  localparam logic [31:0] KIND_LONG_POS      = 32'h0000_2711; // 10001
  localparam logic [31:0] KIND_SHORT_POS     = 32'h0000_2712; // 10002
  localparam logic [31:0] KIND_FLAT_RISE     = 32'h0000_2713; // 10003
  localparam logic [31:0] KIND_STEEP_RISE    = 32'h0000_2714; // 10004
  localparam logic [31:0] KIND_FALL          = 32'h0000_271A; // 10010
  localparam logic [31:0] KIND_LONG_NEG      = 32'h0000_271B; // 10011
  localparam logic [31:0] KIND_SHORT_NEG     = 32'h0000_271C; // 10012
  localparam logic [31:0] KIND_FLAT_FALL     = 32'h0000_271D; // 10013
  localparam logic [31:0] KIND_STEEP_FALL    = 32'h0000_271E; // 10014
  localparam logic [31:0] KIND_OFF           = 32'h0000_2724; // 10020
  localparam logic [31:0] KIND_EITHER        = 32'h0000_272E; // 10030
  // ==========================================================
  // widths and reset values
  localparam int          SAMPLE_W           = 12;
  localparam int          LEVEL_W            = 8;
  localparam int          SPAN_W             = 8;
  localparam logic [7:0]  LEVEL_MIN          = 8'h81; // -127
  localparam logic [7:0]  SPAN_RESET         = 8'h02;
  localparam logic [31:0] KIND_RESET         = KIND_OFF;
  localparam logic [31:0] SRC_RESET          = 32'h0000_0000;
  localparam int          IRQ_TRIG_BIT       = 0;
  localparam int          IRQ_ABORT_BIT      = 1;
  localparam int          IRQ_W              = 2;
  typedef enum logic [1:0] {
    ST_IDLE,
    ST_TIMING
  } cltd_state_e;
endpackage

// >>> design/cltd_detector.sv
// Purpose: per-channel level trigger detector with register port and irq
// Assumes: sample_valid marks each new converted sample, same clock
// Notes:   single clock, synchronous active-high reset
// Function
// RL1: every valid sample is evaluated, no gaps between evaluations
// RL2: rising edge kind triggers on upper threshold crossed upward
// RL3: falling edge kind triggers on upper threshold crossed downward
// RL4: either edge kind triggers on any upper threshold crossing
// RL5: software selects per-channel source and writes upper threshold
// RL6: long positive pulse: rise starts count, expiry without fall triggers
// RL7: long negative pulse: fall starts count, rise aborts, expiry triggers
// RL8: short positive pulse: rise starts, fall before expiry triggers
// RL9: short negative pulse: fall starts, rise before expiry triggers
// RL10: flat rising: lower rise starts, upper crossing aborts, expiry triggers
// RL11: flat falling: upper fall starts, lower crossing aborts, expiry triggers
// RL12: steep rising: lower rise starts, upper crossing before expiry triggers
// RL13: software keeps pulse span between 2 and 255 samples
// RL14: software loads both thresholds before steepness kinds
// RL15: steep falling: upper fall starts, lower reached before expiry triggers
// RL16: signed symmetric thresholds compared with sample top bits
// RL17: measurement end clears counter and returns to waiting for start
// RL18: trigger is one-cycle pulse; reset clears counter and previous sample
//
// Design decision made here: strobed register access.
`timescale 1ns/1ps
module cltd_detector
  import cltd_pkg::*;
(
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire logic                  sample_valid,
  input  wire logic [SAMPLE_W-1:0]   sample_data,
  input  wire logic [15:0]           reg_addr,
  input  wire logic [31:0]           reg_wdata,
  input  wire logic                  reg_wr,
  input  wire logic                  reg_rd,
  output logic      [31:0]           reg_rdata,
  output logic                       trigger_out,
  output logic                       irq
);
  // ==========================================================
  // state
  typedef struct packed {
    logic [31:0]         source_select;
    logic [31:0]         kind;
    logic [LEVEL_W-1:0]  upper;
    logic [LEVEL_W-1:0]  lower;
    logic [SPAN_W-1:0]   span;
    logic [IRQ_W-1:0]    irq_status;
    logic [IRQ_W-1:0]    irq_mask;
    logic [LEVEL_W-1:0]  prev;
    logic                prev_ok;
    cltd_state_e         state;
    logic [SPAN_W-1:0]   count;
    logic                trig;
    logic [31:0]         rdata;
  } cltd_reg_s;

  cltd_reg_s r_ff;
  cltd_reg_s nxt_r;

  // ==========================================================
  // comparison helpers
  logic signed [LEVEL_W-1:0] cur;
  logic signed [LEVEL_W-1:0] prv;
  logic signed [LEVEL_W-1:0] up_lvl;
  logic signed [LEVEL_W-1:0] lo_lvl;
  logic                      up_rise;
  logic                      up_fall;
  logic                      lo_rise;
  logic                      lo_fall;
  logic                      armed;
  logic                      start;
  logic                      hit;
  logic                      stop;
  logic                      expire_trig;
  logic                      timed_kind;

  // top bits of each sample against the level
  assign cur    = sample_data[SAMPLE_W-1 -: LEVEL_W]; // RL16
  assign prv    = r_ff.prev;
  assign up_lvl = r_ff.upper;
  assign lo_lvl = r_ff.lower;
  // crossing means from one side to the other, equality counts as reached
  assign up_rise = r_ff.prev_ok && (prv < up_lvl) && (cur >= up_lvl);
  assign up_fall = r_ff.prev_ok && (prv > up_lvl) && (cur <= up_lvl);
  assign lo_rise = r_ff.prev_ok && (prv < lo_lvl) && (cur >= lo_lvl);
  assign lo_fall = r_ff.prev_ok && (prv > lo_lvl) && (cur <= lo_lvl);
  assign armed   = (r_ff.source_select == SRC_PER_CHANNEL); // RL5

  // per kind: start event, in-window event, whether hit triggers or expiry
  always_comb
  begin
    start       = 1'b0;
    hit         = 1'b0;
    stop        = 1'b0;
    expire_trig = 1'b0;
    timed_kind  = 1'b1;
    unique case (r_ff.kind)
      KIND_RISE:
      begin
        timed_kind = 1'b0;
        stop       = up_rise; // RL2
      end
      KIND_FALL:
      begin
        timed_kind = 1'b0;
        stop       = up_fall; // RL3
      end
      KIND_EITHER:
      begin
        timed_kind = 1'b0;
        stop       = up_rise | up_fall; // RL4
      end
      KIND_LONG_POS:
      begin
        start       = up_rise; // RL6
        hit         = up_fall;
        expire_trig = 1'b1;
      end
      KIND_LONG_NEG:
      begin
        start       = up_fall; // RL7
        hit         = up_rise;
        expire_trig = 1'b1;
      end
      KIND_SHORT_POS:
      begin
        start = up_rise; // RL8
        hit   = up_fall;
        stop  = 1'b1;
      end
      KIND_SHORT_NEG:
      begin
        start = up_fall; // RL9
        hit   = up_rise;
        stop  = 1'b1;
      end
      KIND_FLAT_RISE:
      begin
        start       = lo_rise; // RL10
        hit         = up_rise;
        expire_trig = 1'b1;
      end
      KIND_FLAT_FALL:
      begin
        start       = up_fall; // RL11
        hit         = lo_fall;
        expire_trig = 1'b1;
      end
      KIND_STEEP_RISE:
      begin
        start = lo_rise; // RL12
        hit   = up_rise;
        stop  = 1'b1;
      end
      KIND_STEEP_FALL:
      begin
        start = up_fall; // RL15
        hit   = lo_fall;
        stop  = 1'b1;
      end
      default:
      begin
        timed_kind = 1'b0;
      end
    endcase
  end

  // ==========================================================
  // next state
  logic [31:0] rd_mux;
  logic        ev_trig;
  logic        ev_abort;

  always_comb
  begin
    nxt_r    = r_ff;
    ev_trig  = 1'b0;
    ev_abort = 1'b0;
    nxt_r.trig = 1'b0; // RL18

    // evaluation on each valid sample
    if (sample_valid) // RL1
    begin
      nxt_r.prev    = cur;
      nxt_r.prev_ok = 1'b1;
      // edge kinds decide on this sample alone
      if (!armed || !timed_kind)
      begin
        nxt_r.state = ST_IDLE;
        nxt_r.count = '0;
        ev_trig     = armed && !timed_kind && stop;
      end
      else
      begin
        unique case (r_ff.state)
          ST_IDLE:
          begin
            if (start)
            begin
              nxt_r.state = ST_TIMING;
              nxt_r.count = 8'h01;
            end
          end
          ST_TIMING:
          begin
            if (hit)
            begin
              // stop marks kinds where an in-window crossing triggers
              ev_trig     = stop;
              ev_abort    = !stop;
              nxt_r.state = ST_IDLE; // RL17
              nxt_r.count = '0;
            end
            else if (r_ff.count >= r_ff.span)
            begin
              ev_trig     = expire_trig;
              ev_abort    = !expire_trig;
              nxt_r.state = ST_IDLE; // RL17
              nxt_r.count = '0;
            end
            else
            begin
              nxt_r.count = r_ff.count + 8'h01;
            end
          end
        endcase
      end
    end
    nxt_r.trig = ev_trig; // RL18

    // register writes
    if (reg_wr)
    begin
      unique case (reg_addr)
        ADDR_SOURCE_SELECT: nxt_r.source_select = reg_wdata;
        ADDR_CH0_KIND:
        begin
          nxt_r.kind  = reg_wdata;
          // a new kind must not inherit a running count
          nxt_r.state = ST_IDLE;
          nxt_r.count = '0;
        end
        ADDR_CH0_UPPER:
        begin
          // most negative code is not a legal level
          nxt_r.upper = (reg_wdata[7:0] == 8'h80) ? LEVEL_MIN : reg_wdata[7:0]; // RL16
        end
        ADDR_CH0_LOWER:
        begin
          nxt_r.lower = (reg_wdata[7:0] == 8'h80) ? LEVEL_MIN : reg_wdata[7:0]; // RL16
        end
        ADDR_PULSE_SPAN:    nxt_r.span      = reg_wdata[SPAN_W-1:0];
        ADDR_IRQ_STATUS:    nxt_r.irq_status = r_ff.irq_status & ~reg_wdata[IRQ_W-1:0];
        ADDR_IRQ_MASK:      nxt_r.irq_mask   = reg_wdata[IRQ_W-1:0];
        default:
        begin
          // unmapped or read-only: write ignored
        end
      endcase
    end

    // hardware set wins over software clear
    if (ev_trig)
    begin
      nxt_r.irq_status[IRQ_TRIG_BIT] = 1'b1;
    end
    if (ev_abort)
    begin
      nxt_r.irq_status[IRQ_ABORT_BIT] = 1'b1;
    end

    // register reads
    rd_mux = 32'h0000_0000;
    unique case (reg_addr)
      ADDR_SOURCE_SELECT: rd_mux = r_ff.source_select;
      ADDR_CH0_KIND:      rd_mux = r_ff.kind;
      ADDR_CH0_UPPER:     rd_mux = {{24{r_ff.upper[7]}}, r_ff.upper};
      ADDR_CH0_LOWER:     rd_mux = {{24{r_ff.lower[7]}}, r_ff.lower};
      ADDR_PULSE_SPAN:    rd_mux = {24'h000000, r_ff.span};
      ADDR_IRQ_STATUS:    rd_mux = {30'h0000_0000, r_ff.irq_status};
      ADDR_IRQ_MASK:      rd_mux = {30'h0000_0000, r_ff.irq_mask};
      ADDR_DET_STATUS:    rd_mux = {15'h0000, r_ff.count, 7'h00, r_ff.prev_ok,
                                    r_ff.state == ST_TIMING};
      default:            rd_mux = 32'h0000_0000;
    endcase
    nxt_r.rdata = reg_rd ? rd_mux : 32'h0000_0000;
  end

  // ==========================================================
  // registers
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      r_ff.source_select <= SRC_RESET;
      r_ff.kind          <= KIND_RESET;
      r_ff.upper         <= 8'h00;
      r_ff.lower         <= 8'h00;
      r_ff.span          <= SPAN_RESET;
      r_ff.irq_status    <= 2'h0;
      r_ff.irq_mask      <= 2'h0;
      r_ff.prev          <= 8'h00; // RL18
      r_ff.prev_ok       <= 1'b0;
      r_ff.state         <= ST_IDLE;
      r_ff.count         <= 8'h00; // RL18
      r_ff.trig          <= 1'b0;
      r_ff.rdata         <= 32'h0000_0000;
    end
    else
    begin
      r_ff <= nxt_r;
    end
  end

  assign reg_rdata   = r_ff.rdata;
  assign trigger_out = r_ff.trig;
  assign irq         = |(r_ff.irq_status & r_ff.irq_mask);
endmodule

// >>> bench/cltd_detector_checker.sv
// Purpose: port checks for cltd_detector
// Assumes: register values shadowed from bus writes
// Notes:   bound to every cltd_detector
`timescale 1ns/1ps
module cltd_detector_checker
  import cltd_pkg::*;
(
  input wire logic        clk,
  input wire logic        rst,
  input wire logic        sample_valid,
  input wire logic [11:0] sample_data,
  input wire logic [15:0] reg_addr,
  input wire logic [31:0] reg_wdata,
  input wire logic        reg_wr,
  input wire logic        reg_rd,
  input wire logic [31:0] reg_rdata,
  input wire logic        trigger_out,
  input wire logic        irq
);
  // ==========================================================
  // shadow state
  logic        [31:0] src_ff;
  logic        [31:0] kind_ff;
  logic signed [7:0]  up_ff;
  logic signed [7:0]  prev_ff;
  logic               pv_ff;
  logic        [1:0]  mask_ff;
  wire  signed [7:0]  cur  = sample_data[11:4];
  wire                armed = src_ff == SRC_PER_CHANNEL;
  wire                up_x = pv_ff && prev_ff < up_ff && cur >= up_ff;
  wire                dn_x = pv_ff && prev_ff > up_ff && cur <= up_ff;
  always_ff @(posedge clk)
  begin
    if (rst)
    begin
      src_ff  <= SRC_RESET;
      kind_ff <= KIND_RESET;
      up_ff   <= 8'h00;
      pv_ff   <= 1'h0;
      mask_ff <= 2'h0;
    end
    else
    begin
      if (reg_wr && reg_addr == ADDR_SOURCE_SELECT)
        src_ff <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CH0_KIND)
        kind_ff <= reg_wdata;
      if (reg_wr && reg_addr == ADDR_CH0_UPPER)
        up_ff <= (reg_wdata[7:0] == 8'h80) ? LEVEL_MIN : reg_wdata[7:0];
      if (reg_wr && reg_addr == ADDR_IRQ_MASK)
        mask_ff <= reg_wdata[1:0];
      if (sample_valid)
        pv_ff <= 1'h1;
    end
    if (sample_valid)
      prev_ff <= cur;
  end
  // ==========================================================
  // assertions
  default clocking cb @(posedge clk);
  endclocking
  default disable iff (rst);
  sequence s_up;
    sample_valid && armed && up_x;
  endsequence
  sequence s_dn;
    sample_valid && armed && dn_x;
  endsequence
  a_rise_fires: assert property (kind_ff == KIND_RISE ##0 s_up |=> trigger_out)
    else $error("rising crossing gave no trigger");
  a_fall_fires: assert property (kind_ff == KIND_FALL ##0 s_dn |=> trigger_out)
    else $error("falling crossing gave no trigger");
  a_either_fires: assert property (kind_ff == KIND_EITHER ##0 (s_up or s_dn)
    |=> trigger_out) else $error("either kind missed a crossing");
  a_rise_only: assert property (kind_ff == KIND_RISE && sample_valid && !up_x
    |=> !trigger_out) else $error("rise kind fired without crossing");
  a_src_gate: assert property (!armed |=> !trigger_out)
    else $error("trigger without channel source");
  a_kind_off: assert property (kind_ff == KIND_OFF |=> !trigger_out)
    else $error("trigger with kind off");
  a_no_sample: assert property (!sample_valid |=> !trigger_out)
    else $error("trigger without a sample");
  a_rdata_idle: assert property (!reg_rd |=> reg_rdata == 32'h0)
    else $error("read data outside read cycle");
  a_level_sext: assert property (reg_rd && reg_addr == ADDR_CH0_UPPER
    |=> reg_rdata == {{24{up_ff[7]}}, up_ff}) else $error("upper level readback");
  a_irq_follows: assert property (trigger_out && mask_ff[IRQ_TRIG_BIT] |-> irq)
    else $error("unmasked trigger left irq low");
endmodule
bind cltd_detector cltd_detector_checker u_chk (
  .clk         (clk),
  .rst         (rst),
  .sample_valid(sample_valid),
  .sample_data (sample_data),
  .reg_addr    (reg_addr),
  .reg_wdata   (reg_wdata),
  .reg_wr      (reg_wr),
  .reg_rd      (reg_rd),
  .reg_rdata   (reg_rdata),
  .trigger_out (trigger_out),
  .irq         (irq)
);

// >>> bench/test_channel_level_trigger_detector.sv
// Purpose: register and trigger scenarios for cltd_detector
// Assumes: upper 10, lower -10, span 3, one sample per cycle
// Notes:   each run feeds eight samples and counts trigger pulses
`timescale 1ns/1ps
module test_channel_level_trigger_detector
  import cltd_pkg::*;
;
  localparam logic [63:0] PA = 64'h0014_0014_1414_1400;
  localparam logic [63:0] PB = 64'h1400_1400_0000_0000;
  localparam logic [63:0] PC = 64'hEC00_14EC_0000_0000;
  localparam logic [63:0] PD = 64'h1400_EC14_0000_0000;
  logic        clk = 1'h0;
  logic        rst = 1'h1;
  logic        sample_valid = 1'h0;
  logic [11:0] sample_data = 12'h000;
  logic [15:0] reg_addr = 16'h0000;
  logic [31:0] reg_wdata = 32'h0;
  logic        reg_wr = 1'h0;
  logic        reg_rd = 1'h0;
  logic [31:0] reg_rdata;
  logic        trigger_out;
  logic        irq;
  int          fails = 0;
  int          total_checks = 0;
  int          trig_n = 0;
  initial
    forever #4 clk = ~clk;
  cltd_detector DUT (
    .clk(clk), .rst(rst), .sample_valid(sample_valid), .sample_data(sample_data),
    .reg_addr(reg_addr), .reg_wdata(reg_wdata), .reg_wr(reg_wr), .reg_rd(reg_rd),
    .reg_rdata(reg_rdata), .trigger_out(trigger_out), .irq(irq)
  );
  always @(posedge clk)
    if (trigger_out === 1'h1)
      trig_n++;
  // ==========================================================
  // tasks
  task summarize();
    $display("checks %0d mismatches %0d", total_checks, fails);
    if (fails == 0 && total_checks > 0)
      $display("ALL TESTS PASSED");
    else
      $display("TESTS FAILED");
    $finish;
  endtask
  task check(input string what, input logic [31:0] seen, input logic [31:0] exp);
    total_checks++;
    if (seen !== exp)
    begin
      fails++;
      $display("wrong value %s expected %h seen %h", what, exp, seen);
    end
  endtask
  task wr(input logic [15:0] a, input logic [31:0] d);
    @(posedge clk);
    reg_wr <= 1'h1;
    reg_addr <= a;
    reg_wdata <= d;
    @(posedge clk);
    reg_wr <= 1'h0;
    #1;
  endtask
  task rd(input string what, input logic [15:0] a, input logic [31:0] exp);
    @(posedge clk);
    reg_rd <= 1'h1;
    reg_addr <= a;
    @(posedge clk);
    reg_rd <= 1'h0;
    #1;
    check(what, reg_rdata, exp);
  endtask
  // samples carry the level in the top eight bits
  task run(input logic [31:0] kind, input logic [63:0] seq, input int exp);
    wr(ADDR_CH0_KIND, kind);
    trig_n = 0;
    for (int i = 0; i < 8; i++)
    begin
      @(posedge clk);
      sample_valid <= 1'h1;
      sample_data <= {seq[63-8*i -: 8], 4'h0};
    end
    @(posedge clk);
    sample_valid <= 1'h0;
    repeat (3) @(posedge clk);
    check("triggers", trig_n, exp);
  endtask
  // ==========================================================
  // sequence
  initial
  begin
    #100000;
    fails++;
    summarize();
  end
  initial
  begin
    repeat (5) @(posedge clk);
    rst <= 1'h0;
    rd("kind reset", ADDR_CH0_KIND, KIND_RESET);
    rd("span reset", ADDR_PULSE_SPAN, {24'h0, SPAN_RESET});
    rd("source reset", ADDR_SOURCE_SELECT, SRC_RESET);
    rd("mask reset", ADDR_IRQ_MASK, 32'h0);
    rd("detector idle", ADDR_DET_STATUS, 32'h0);
    wr(16'h1234, 32'h5);
    rd("unmapped", 16'h1234, 32'h0);
    wr(ADDR_CH0_UPPER, 32'h80);
    rd("upper clip", ADDR_CH0_UPPER, 32'hFFFF_FF81);
    wr(ADDR_CH0_UPPER, 32'h0A);
    wr(ADDR_CH0_LOWER, 32'hF6);
    rd("lower", ADDR_CH0_LOWER, 32'hFFFF_FFF6);
    wr(ADDR_PULSE_SPAN, 32'h3);
    run(KIND_RISE, PA, 0);
    wr(ADDR_SOURCE_SELECT, SRC_PER_CHANNEL);
    run(KIND_OFF, PA, 0);
    run(KIND_RISE, PA, 2);
    run(KIND_FALL, PA, 2);
    run(KIND_EITHER, PA, 4);
    wr(ADDR_IRQ_STATUS, 32'h3);
    run(KIND_LONG_POS, PA, 1);
    rd("status", ADDR_IRQ_STATUS, 32'h3);
    check("irq masked", irq, 32'h0);
    wr(ADDR_IRQ_MASK, 32'h1);
    check("irq", irq, 32'h1);
    wr(ADDR_IRQ_STATUS, 32'h1);
    check("irq cleared", irq, 32'h0);
    rd("status left", ADDR_IRQ_STATUS, 32'h2);
    wr(ADDR_PULSE_SPAN, 32'h4);
    run(KIND_LONG_POS, PA, 0);
    wr(ADDR_PULSE_SPAN, 32'h3);
    run(KIND_SHORT_POS, PA, 1);
    run(KIND_LONG_NEG, PB, 1);
    run(KIND_SHORT_NEG, PB, 1);
    run(KIND_FLAT_RISE, PC, 1);
    run(KIND_STEEP_RISE, PC, 1);
    run(KIND_FLAT_FALL, PD, 1);
    run(KIND_STEEP_FALL, PD, 1);
    // clear and trigger on one edge: the trigger bit must survive
    wr(ADDR_CH0_KIND, KIND_RISE);
    @(posedge clk);
    sample_valid <= 1'h1;
    sample_data <= 12'h140;
    reg_wr <= 1'h1;
    reg_addr <= ADDR_IRQ_STATUS;
    reg_wdata <= 32'h3;
    @(posedge clk);
    sample_valid <= 1'h0;
    reg_wr <= 1'h0;
    rd("set wins", ADDR_IRQ_STATUS, 32'h1);
    // start a long pulse, then reset in mid-measurement
    wr(ADDR_CH0_KIND, KIND_LONG_POS);
    @(posedge clk);
    sample_valid <= 1'h1;
    sample_data <= 12'h000;
    @(posedge clk);
    sample_data <= 12'h140;
    @(posedge clk);
    sample_valid <= 1'h0;
    rd("timing", ADDR_DET_STATUS, 32'h0000_0203);
    @(posedge clk);
    rst <= 1'h1;
    repeat (2) @(posedge clk);
    rst <= 1'h0;
    rd("reset clears", ADDR_DET_STATUS, 32'h0);
    rd("kind after reset", ADDR_CH0_KIND, KIND_RESET);
    summarize();
  end
endmodule
